// [include/utd_pkg.sv]
// Purpose: shared constants for the transmit dma request block
// Assumes: two serial channels, one 125 MHz clock
// Notes: depths are fixed; counts are wide enough for a full fifo
`default_nettype none

package utd_pkg;

  // channel count and storage depths
  localparam int NUM_CH = 2;
  localparam int COUNT_W = 5;
  localparam logic [COUNT_W-1:0] TX_FIFO_DEPTH = 5'h10;
  localparam logic [COUNT_W-1:0] TX_HOLD_DEPTH = 5'h01;

  // reset values
  localparam logic [COUNT_W-1:0] COUNT_RESET = 5'h00;
  localparam logic REQUEST_N_RESET = 1'b0;
  localparam logic FILLING_RESET = 1'b1;
  localparam logic FLOAT_RESET = 1'b0;
  localparam logic FIFO_EN_RESET = 1'b0;

  // dma signalling modes, picked by the mode select bit
  typedef enum logic [0:0]
  {
    UTD_MODE_SINGLE = 1'b0,
    UTD_MODE_MULTI = 1'b1
  } utd_dma_mode_e;

endpackage : utd_pkg

`default_nettype wire

// [hdl/utd_tx_dma_ready.sv]
// Purpose: transmit dma request signalling for two serial channels
// Assumes: load and unload strobes are one-cycle pulses on core_clk
// Notes: float test input is asynchronous and passes a two-flop synchroniser
//
// Contract
// - each channel drives own independent request output
// - fifo mode: mode select bit picks signalling
// - fifo off: single-transfer signalling only
// - mode 0: request low when storage empty
// - mode 0: request high after first write
// - mode 1: request low when fifo empty
// - mode 1: stays low until fifo full
// - float test input releases both request pins, fill levels stay driven
`default_nettype none

module utd_tx_dma_ready
  import utd_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // board test float control, asynchronous pin
  input wire logic output_float_test,
  // channel 0 control bits from its fifo_control_reg
  input wire logic ch0_fifo_enable_bit,
  input wire logic ch0_dma_signal_mode_bit,
  // channel 0 transmitter strobes
  input wire logic ch0_char_load,
  input wire logic ch0_char_unload,
  // channel 0 request pin and fill level
  output var logic ch0_tx_dma_request_n,
  output var logic ch0_tx_dma_request_oe,
  output var logic [COUNT_W-1:0] ch0_tx_fill_level,
  // channel 1 control bits from its fifo_control_reg
  input wire logic ch1_fifo_enable_bit,
  input wire logic ch1_dma_signal_mode_bit,
  // channel 1 transmitter strobes
  input wire logic ch1_char_load,
  input wire logic ch1_char_unload,
  // channel 1 request pin and fill level
  output var logic ch1_tx_dma_request_n,
  output var logic ch1_tx_dma_request_oe,
  output var logic [COUNT_W-1:0] ch1_tx_fill_level
);

  // storage depth in the current mode
  function automatic logic [COUNT_W-1:0] depth_of(input logic fifo_on);
    depth_of = fifo_on ? TX_FIFO_DEPTH : TX_HOLD_DEPTH;
  endfunction

  // empty test, shared by refusal, hysteresis and request terms
  function automatic logic is_empty(input logic [COUNT_W-1:0] level);
    is_empty = (level == COUNT_RESET);
  endfunction

  // full test against the depth of the current mode
  function automatic logic is_full(input logic [COUNT_W-1:0] level, input logic [COUNT_W-1:0] depth);
    is_full = (level >= depth);
  endfunction

  // effective signalling mode
  function automatic utd_dma_mode_e mode_of(input logic fifo_on, input logic sel);
    if (fifo_on && sel)
    begin
      mode_of = UTD_MODE_MULTI;
    end
    else
    begin
      mode_of = UTD_MODE_SINGLE;
    end
  endfunction

  // per-channel views of the ports
  logic [NUM_CH-1:0] fifo_en_in;
  logic [NUM_CH-1:0] mode_sel_in;
  logic [NUM_CH-1:0] load_in;
  logic [NUM_CH-1:0] unload_in;

  assign fifo_en_in = {ch1_fifo_enable_bit, ch0_fifo_enable_bit};
  assign mode_sel_in = {ch1_dma_signal_mode_bit, ch0_dma_signal_mode_bit};
  assign load_in = {ch1_char_load, ch0_char_load};
  assign unload_in = {ch1_char_unload, ch0_char_unload};

  // synchroniser for the float pin
  // two flops: the test pin is not timed to core_clk
  logic float_meta;
  logic float_sync;
  logic next_float_meta;
  logic next_float_sync;

  always_comb
  begin
    next_float_meta = output_float_test;
    next_float_sync = float_meta;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      float_meta <= FLOAT_RESET;
      float_sync <= FLOAT_RESET;
    end
    else
    begin
      float_meta <= next_float_meta;
      float_sync <= next_float_sync;
    end
  end

  // per-channel state
  logic [COUNT_W-1:0] count [NUM_CH];
  logic [NUM_CH-1:0] filling;
  logic [NUM_CH-1:0] fifo_en_last;
  logic [NUM_CH-1:0] request_n;
  logic [NUM_CH-1:0] request_oe;
  logic [COUNT_W-1:0] next_count [NUM_CH];
  logic [NUM_CH-1:0] next_filling;
  logic [NUM_CH-1:0] next_fifo_en_last;
  logic [NUM_CH-1:0] next_request_n;
  logic [NUM_CH-1:0] next_request_oe;

  always_comb
  begin
    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      logic [COUNT_W-1:0] depth;
      logic do_load;
      logic do_unload;
      depth = depth_of(fifo_en_in[ch]);
      // a load into full storage is dropped, an unload from empty too
      do_load = load_in[ch] && !is_full(count[ch], depth);
      do_unload = unload_in[ch] && !is_empty(count[ch]);
      next_fifo_en_last[ch] = fifo_en_in[ch];
      if (fifo_en_in[ch] != fifo_en_last[ch])
      begin
        // switching fifo mode flushes the transmit side
        next_count[ch] = COUNT_RESET;
      end
      else if (do_load && !do_unload)
      begin
        next_count[ch] = count[ch] + 5'h01;
      end
      else if (do_unload && !do_load)
      begin
        next_count[ch] = count[ch] - 5'h01;
      end
      else
      begin
        next_count[ch] = count[ch];
      end
      // multi-transfer hysteresis, tracked always so a mode switch is clean
      if (is_empty(next_count[ch]))
      begin
        next_filling[ch] = 1'b1;
      end
      else if (is_full(next_count[ch], depth))
      begin
        next_filling[ch] = 1'b0;
      end
      else
      begin
        next_filling[ch] = filling[ch];
      end
      // built from next values so pin and level move together
      unique case (mode_of(fifo_en_in[ch], mode_sel_in[ch]))
        UTD_MODE_SINGLE:
        begin
          // low only while empty, high after the first load
          next_request_n[ch] = !is_empty(next_count[ch]);
        end
        UTD_MODE_MULTI:
        begin
          next_request_n[ch] = !next_filling[ch];
        end
      endcase
      // float drops only the enable, the request keeps tracking
      next_request_oe[ch] = !float_sync;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      for (int ch = 0; ch < NUM_CH; ch++)
      begin
        count[ch] <= COUNT_RESET;
      end
      filling <= {NUM_CH{FILLING_RESET}};
      fifo_en_last <= {NUM_CH{FIFO_EN_RESET}};
      request_n <= {NUM_CH{REQUEST_N_RESET}};
      request_oe <= {NUM_CH{!FLOAT_RESET}};
    end
    else
    begin
      for (int ch = 0; ch < NUM_CH; ch++)
      begin
        count[ch] <= next_count[ch];
      end
      filling <= next_filling;
      fifo_en_last <= next_fifo_en_last;
      request_n <= next_request_n;
      request_oe <= next_request_oe;
    end
  end

  // each pin sees only its own channel
  // enable high means the pin is driven
  assign ch0_tx_dma_request_n = request_n[0];
  assign ch1_tx_dma_request_n = request_n[1];
  assign ch0_tx_dma_request_oe = request_oe[0];
  assign ch1_tx_dma_request_oe = request_oe[1];
  assign ch0_tx_fill_level = count[0];
  assign ch1_tx_fill_level = count[1];

endmodule // utd_tx_dma_ready

`default_nettype wire

// [tb/utd_dma_model.sv]
// Purpose: dma controller filling channel 0
// Assumes: request sampled at rising edge
// Notes: burst only where multi transfer is set
`default_nettype none
module utd_dma_model
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ch0_tx_dma_request_n,
  input wire logic en,
  input wire logic bu,
  output var logic ch0_char_load
);
  timeunit 1ns;
  timeprecision 1ps;
  logic next_load;
  always_comb
  begin
    next_load = en && !ch0_tx_dma_request_n && (bu || !ch0_char_load);
  end
  always_ff @(posedge core_clk)
  begin
    ch0_char_load <= reset ? 1'b0 : next_load;
  end
endmodule // utd_dma_model
`default_nettype wire

// [tb/utd_tx_dma_ready_properties.sv]
// Purpose: port checks of channel 0, isolation of channel 1
// Assumes: one clock, sync reset
// Notes: mode changes are masked one cycle
`default_nettype none
module utd_tx_dma_ready_checker
  import utd_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic output_float_test,
  input wire logic ch0_fifo_enable_bit,
  input wire logic ch0_dma_signal_mode_bit,
  input wire logic ch0_char_load,
  input wire logic ch0_tx_dma_request_n,
  input wire logic ch0_tx_dma_request_oe,
  input wire logic [COUNT_W-1:0] ch0_tx_fill_level,
  input wire logic ch1_char_load,
  input wire logic ch1_char_unload,
  input wire logic [COUNT_W-1:0] ch1_tx_fill_level
);
  wire m1 = ch0_fifo_enable_bit & ch0_dma_signal_mode_bit;
  wire rq = ch0_tx_dma_request_n;
  wire [COUNT_W-1:0] f = ch0_tx_fill_level;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  a_empty_req_low: assert property (f == COUNT_RESET |-> !rq)
    else $error("request high when empty");
  a_load_req_high: assert property (!m1 && $stable(ch0_fifo_enable_bit) && ch0_char_load |=> rq)
    else $error("request low after load");
  a_single_high: assert property (!m1 && !$past(m1) && f != COUNT_RESET |-> rq)
    else $error("single mode request low");
  a_multi_rise: assert property (m1 && $past(m1) && $rose(rq) |-> f == TX_FIFO_DEPTH)
    else $error("multi request early");
  a_multi_full: assert property (m1 && f == TX_FIFO_DEPTH |-> rq)
    else $error("multi request low when full");
  a_float_off: assert property (output_float_test [*3] |=> !ch0_tx_dma_request_oe)
    else $error("pin driven in float");
  a_float_on: assert property (!output_float_test [*3] |=> ch0_tx_dma_request_oe)
    else $error("pin floats");
  a_chan_alone: assert property (!ch1_char_load && !ch1_char_unload |=> $stable(ch1_tx_fill_level))
    else $error("channel 1 level moved");
  c_full: cover property (m1 && f == TX_FIFO_DEPTH);
  c_float: cover property (!ch0_tx_dma_request_oe);
  c_single: cover property (!m1 && ch0_char_load);
endmodule // utd_tx_dma_ready_checker
bind utd_tx_dma_ready utd_tx_dma_ready_checker i_utd_tx_dma_ready_checker (.*);
`default_nettype wire

// [tb/utd_tx_dma_ready_tb_top.sv]
// Purpose: bench of the transmit dma request block
// Assumes: channel 1 idle until a two-cycle load near the end, channel 0 fed by model
// Notes: rows are fifo, mode, burst, expected fill
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; $display("[FAIL] %0t %h %h", $time, a, e); end end
module utd_tx_dma_ready_tb_top;
  import utd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, reset = 1'b1, output_float_test = 1'b0, en = 1'b0, bu = 1'b0;
  logic ch0_fifo_enable_bit = 1'b0, ch0_dma_signal_mode_bit = 1'b0, ch0_char_unload = 1'b0;
  logic ch1_fifo_enable_bit = 1'b0, ch1_dma_signal_mode_bit = 1'b0, ch1_char_load = 1'b0, ch1_char_unload = 1'b0;
  logic ch0_char_load, ch0_tx_dma_request_n, ch0_tx_dma_request_oe, ch1_tx_dma_request_n, ch1_tx_dma_request_oe;
  logic [COUNT_W-1:0] ch0_tx_fill_level, ch1_tx_fill_level;
  int err_total = 0, n_tests = 0;
  logic [7:0] rows [4] = '{8'h01, 8'h41, 8'h81, 8'hf0};
  utd_tx_dma_ready i_utd_tx_dma_ready (.*);
  utd_dma_model i_utd_dma_model (.*);
  always #4 core_clk = ~core_clk;
  task automatic final_report;
    if (err_total == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #5000;
    err_total++;
    final_report();
  end
  initial
  begin
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    `CHK(ch0_tx_dma_request_n, REQUEST_N_RESET)
    foreach (rows[i])
    begin
      {ch0_fifo_enable_bit, ch0_dma_signal_mode_bit, bu} <= rows[i][7:5];
      en <= 1'b1;
      repeat (30) @(posedge core_clk);
      `CHK(ch0_tx_fill_level, rows[i][4:0])
      `CHK(ch0_tx_dma_request_n, 1'b1)
      `CHK(ch1_tx_dma_request_n, 1'b0)
      en <= 1'b0;
      ch0_char_unload <= 1'b1;
      repeat (20) @(posedge core_clk);
      ch0_char_unload <= 1'b0;
      repeat (2) @(posedge core_clk);
      `CHK(ch0_tx_dma_request_n, 1'b0)
    end
    output_float_test <= 1'b1;
    repeat (4) @(posedge core_clk);
    `CHK(ch1_tx_dma_request_oe, 1'b0)
    `CHK(ch0_tx_dma_request_oe, 1'b0)
    output_float_test <= 1'b0;
    repeat (4) @(posedge core_clk);
    `CHK(ch1_tx_dma_request_oe, 1'b1)
    `CHK(ch0_tx_dma_request_oe, 1'b1)
    ch1_char_load <= 1'b1;
    repeat (2) @(posedge core_clk);
    ch1_char_load <= 1'b0;
    repeat (2) @(posedge core_clk);
    `CHK(ch1_tx_fill_level, TX_HOLD_DEPTH)
    `CHK(ch1_tx_dma_request_n, 1'b1)
    `CHK(ch0_tx_fill_level, COUNT_RESET)
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    `CHK(ch1_tx_fill_level, COUNT_RESET)
    `CHK(ch1_tx_dma_request_n, 1'b0)
    `CHK(ch0_tx_dma_request_n, 1'b0)
    final_report();
  end
endmodule // utd_tx_dma_ready_tb_top
`default_nettype wire
